/* logic/seq_pkg.sv */
// constants, field layout and state types of the pressure output sequencer
// assumes a single 200 MHz clock and a 32-bit word-aligned register map
package seq_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_TIME_US = 10000;
   localparam int TICKS_PER_SEC = 100;
   localparam int SWEEP_STEPS = 100;
   // divider ratio limits and value widths
   localparam int DIV_MIN = 1;
   localparam int DIV_MAX = 20;
   localparam int DIGITS = 4;
   localparam int LVL_W = 14;
   localparam int NUM_W = 7;
   localparam logic [3:0] BCD_MAX = 4'h9;
   // register byte offsets
   localparam logic [5:0] OFS_KEY = 6'h00;
   localparam logic [5:0] OFS_STATUS = 6'h04;
   localparam logic [5:0] OFS_SETPT = 6'h08;
   localparam logic [5:0] OFS_STEP_IVL = 6'h0C;
   localparam logic [5:0] OFS_SWEEP_IVL = 6'h10;
   localparam logic [5:0] OFS_DIVIDER = 6'h14;
   localparam logic [5:0] OFS_LEVEL = 6'h18;
   localparam logic [5:0] OFS_DISPLAY = 6'h1C;
   // key register bits, one press per written one
   localparam int K_OUT = 0, K_AUTO = 1, K_RISE = 2, K_FALL = 3, K_IVL = 4;
   localparam int K_RPT = 5, K_HOLD = 6, K_CLR = 7, K_ARST = 8, K_NUP = 9;
   localparam int K_NDN = 10, K_MUP = 11, K_MDN = 12, K_DUP = 13, K_DDN = 14;
   localparam int KEY_W = 15;
   localparam int DIGIT_SEL_LSB = 16;
   // divider register fields
   localparam int DIV_M_LSB = 0;
   localparam int DIV_N_LSB = 8;
   localparam int DIV_W = 5;
   // reset values
   localparam logic [15:0] SETPT_RST = 16'h0000;
   localparam logic [15:0] IVL_RST = 16'h0001;
   localparam logic [4:0] DIV_M_RST = 5'h01;
   localparam logic [4:0] DIV_N_RST = 5'h01;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} seq_t;
   typedef enum logic [1:0] {DISP_STEP_IVL, DISP_SWEEP_IVL, DISP_SETPOINT} disp_t;

   function automatic logic [LVL_W-1:0] bcd_to_bin(input logic [15:0] b);
      return LVL_W'(b[15:12]) * LVL_W'(1000) + LVL_W'(b[11:8]) * LVL_W'(100)
         + LVL_W'(b[7:4]) * LVL_W'(10) + LVL_W'(b[3:0]);
   endfunction
endpackage

/* logic/digit_editor.sv */
// one-digit increment or decrement of a packed decimal value
// assumes one of up or down per cycle; digits wrap 9 to 0 and back
`timescale 1ns/100ps
module digit_editor
   import seq_pkg::*;
#(
   parameter int DIGITS_P = DIGITS
) (
   // value to adjust
   input wire logic [4*DIGITS_P-1:0] value,
   input wire logic [$clog2(DIGITS_P)-1:0] sel,
   input wire logic up,
   input wire logic down,
   // adjusted value
   output logic [4*DIGITS_P-1:0] result
);
   if (DIGITS_P < 2) begin : bad_digits
      $error("digit_editor needs at least two digits");
   end
   for (genvar i = 0; i < DIGITS_P; i++) begin : g_digit
      logic [3:0] d;
      assign d = value[4*i +: 4];
      assign result[4*i +: 4] = (sel != i) ? d :
         up ? ((d >= BCD_MAX) ? 4'h0 : d + 4'h1) :
         down ? ((d == 4'h0) ? BCD_MAX : d - 4'h1) : d;
   end
endmodule

/* logic/level_scaler.sv */
// free-running serial multiply-divide: result = value * num / den
// assumes den >= 1 and num <= den; result lags the inputs by about 22 cycles
`timescale 1ns/100ps
module level_scaler
   import seq_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // operands
   input wire logic [LVL_W-1:0] value,
   input wire logic [NUM_W-1:0] num,
   input wire logic [NUM_W-1:0] den,
   // scaled level, registered
   output logic [LVL_W-1:0] result
);
   localparam int PW = LVL_W + NUM_W;
   typedef struct packed {
      logic [PW-1:0] prod;
      logic [NUM_W-1:0] rem;
      logic [NUM_W-1:0] den;
      logic [4:0] cnt;
      logic [LVL_W-1:0] res;
   } sc_t;
   sc_t sc_q, sc_d;
   logic [NUM_W:0] t;

   // restoring division, one quotient bit per cycle keeps the area tiny
   always_comb begin
      sc_d = sc_q;
      t = {sc_q.rem, sc_q.prod[PW-1]};
      if (!rst_n) begin
         sc_d = '0;
      end else if (sc_q.cnt == 5'h00) begin
         sc_d.res = sc_q.prod[LVL_W-1:0];
         sc_d.prod = PW'(value) * PW'(num);
         sc_d.den = den;
         sc_d.rem = '0;
         sc_d.cnt = 5'(PW);
      end else begin
         sc_d.prod = {sc_q.prod[PW-2:0], 1'b0};
         if (t >= {1'b0, sc_q.den}) begin
            t = t - {1'b0, sc_q.den};
            sc_d.prod[0] = 1'b1;
         end
         sc_d.rem = t[NUM_W-1:0];
         sc_d.cnt = sc_q.cnt - 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      sc_q <= sc_d;
   end
   assign result = sc_q.res;
endmodule

/* logic/pressure_output_sequencer.sv */
// front-panel output-mode controller for a pneumatic pressure calibrator
// assumes key presses arrive as writes to the key register over Avalon-MM
`timescale 1ns/100ps
module pressure_output_sequencer
   import seq_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   // register bus
   input wire logic [5:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // pneumatics
   input wire logic SUPPLY_PRESSURE_FAULT,
   input wire logic [LVL_W-1:0] DELIVERED_PRESSURE,
   output logic [LVL_W-1:0] SERVO_SETPOINT,
   output logic SERVO_ENABLE,
   output logic VALVE_OPEN,
   output logic VALVE_CLOSE,
   // indicators
   output logic LED_OUTPUT,
   output logic LED_AUTO,
   output logic LED_RISE,
   output logic LED_FALL,
   output logic LED_INTERVAL,
   output logic LED_REPEAT,
   output logic LED_HOLD,
   output logic LED_ALARM
);
   if (TICK_CYCLES < 2) begin : bad_tick
      $error("TICK_CYCLES must be at least 2");
   end

   typedef struct packed {
      logic wt;
      logic [31:0] rdata;
      logic [31:0] tick_cnt;
      logic out_on, auto, rise, fall, rpt, hold, alarm, ivl_led, wrapped;
      disp_t disp;
      seq_t seq;
      logic [15:0] setpt, step_ivl, sweep_ivl;
      logic [4:0] m, n, cur;
      logic [6:0] pct;
      logic [19:0] timer;
      logic [LVL_W-1:0] servo;
      logic servo_en, v_open, v_close;
   } state_t;
   state_t st_q, st_d;

   logic req, ack, wr, tick, edit_ok, seq_mode, fin;
   logic [31:0] cur_w, wd, stat_w;
   logic [KEY_W-1:0] kp;
   logic [15:0] disp_val, edited;
   logic [19:0] thr;
   logic [4:0] cur_nx;
   logic [6:0] pct_nx, num_sel, den_sel;
   logic [LVL_W-1:0] scaled;

   assign req = AVS_READ | AVS_WRITE;
   assign ack = req & ~st_q.wt;
   assign wr = AVS_WRITE & ack;
   assign tick = (st_q.tick_cnt == 32'(TICK_CYCLES - 1));
   assign seq_mode = st_q.auto | st_q.rise | st_q.fall;
   assign edit_ok = ~seq_mode;
   assign disp_val = (st_q.disp == DISP_STEP_IVL) ? st_q.step_ivl :
      (st_q.disp == DISP_SWEEP_IVL) ? st_q.sweep_ivl : st_q.setpt;
   assign stat_w = {21'h0, st_q.seq == SEQ_DONE, st_q.alarm, st_q.hold, st_q.rpt,
      st_q.ivl_led, st_q.fall, st_q.rise, st_q.auto, st_q.out_on, st_q.disp};
   assign cur_w = (AVS_ADDRESS == OFS_STATUS) ? stat_w :
      (AVS_ADDRESS == OFS_SETPT) ? {16'h0000, st_q.setpt} :
      (AVS_ADDRESS == OFS_STEP_IVL) ? {16'h0000, st_q.step_ivl} :
      (AVS_ADDRESS == OFS_SWEEP_IVL) ? {16'h0000, st_q.sweep_ivl} :
      (AVS_ADDRESS == OFS_DIVIDER) ? {19'h0, st_q.n, 3'h0, st_q.m} :
      (AVS_ADDRESS == OFS_LEVEL) ? {18'h0, st_q.servo} :
      (AVS_ADDRESS == OFS_DISPLAY) ? {16'h0000, disp_val} : 32'h0000_0000;
   // lanes left out of a write keep their value; the key register reads zero
   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign wd[8*b +: 8] = AVS_BYTEENABLE[b] ? AVS_WRITEDATA[8*b +: 8] : cur_w[8*b +: 8];
   end
   assign kp = (wr && AVS_ADDRESS == OFS_KEY) ? wd[KEY_W-1:0] : '0;

   // level source: manual n/m, auto-step cur/m, sweep percent
   assign num_sel = st_q.auto ? 7'(st_q.cur) : (st_q.rise | st_q.fall) ? st_q.pct
      : 7'(st_q.n);
   assign den_sel = (st_q.rise | st_q.fall) ? 7'(SWEEP_STEPS) : 7'(st_q.m);

   digit_editor #(.DIGITS_P(DIGITS)) u_edit (
      .value(disp_val),
      .sel(wd[DIGIT_SEL_LSB +: 2]),
      .up(kp[K_DUP]),
      .down(kp[K_DDN]),
      .result(edited)
   );

   level_scaler u_scale (
      .clk(CLK),
      .rst_n(RST_N),
      .value(bcd_to_bin(st_q.setpt)),
      .num(num_sel),
      .den(den_sel),
      .result(scaled)
   );

   always_comb begin
      st_d = st_q;
      cur_nx = st_q.cur;
      pct_nx = st_q.pct;
      fin = 1'b0;
      thr = '0;
      // one wait state, then the answer
      st_d.wt = ~(req & st_q.wt);
      if (req && st_q.wt) begin
         st_d.rdata = AVS_READ ? cur_w : st_q.rdata;
      end
      st_d.tick_cnt = tick ? 32'h0000_0000 : st_q.tick_cnt + 32'h0000_0001;
      // sequencing is frozen whole while held
      // a finished sequence stands one full step on its last level before a repeat
      if ((st_q.seq == SEQ_RUN || (st_q.seq == SEQ_DONE && st_q.rpt)) && !st_q.hold
         && tick) begin
         thr = st_q.auto ? 20'(bcd_to_bin(st_q.step_ivl)) * 20'(TICKS_PER_SEC)
            : 20'(bcd_to_bin(st_q.sweep_ivl)) * 20'(TICKS_PER_SEC / SWEEP_STEPS);
         if (thr == '0) begin
            thr = 20'h00001;
         end
         if (st_q.timer + 20'h00001 >= thr) begin
            st_d.timer = '0;
            if (st_q.auto) begin
               cur_nx = (st_q.cur == st_q.m) ? 5'h00 : st_q.cur + 5'h01;
               st_d.wrapped = st_q.wrapped | (st_q.cur == st_q.m);
               fin = st_d.wrapped && cur_nx == st_q.n;
            end else if (st_q.rise) begin
               pct_nx = (st_q.pct >= 7'(SWEEP_STEPS)) ? st_q.pct : st_q.pct + 7'h01;
               fin = pct_nx == 7'(SWEEP_STEPS);
            end else begin
               pct_nx = (st_q.pct == 7'h00) ? st_q.pct : st_q.pct - 7'h01;
               fin = pct_nx == 7'h00;
            end
            st_d.cur = cur_nx;
            st_d.pct = pct_nx;
            if (fin) begin
               st_d.seq = SEQ_DONE;
            end
            if (st_q.seq == SEQ_DONE) begin
               st_d.cur = st_q.n;
               st_d.wrapped = 1'b0;
               st_d.pct = st_q.rise ? 7'h00 : 7'(SWEEP_STEPS);
               st_d.seq = SEQ_RUN;
            end
         end else begin
            st_d.timer = st_q.timer + 20'h00001;
         end
      end
      // mode keys
      if (kp[K_AUTO] && !st_q.out_on) begin
         st_d.auto = ~st_q.auto;
         st_d.rise = 1'b0;
         st_d.fall = 1'b0;
      end
      if (kp[K_RISE]) begin
         if (!st_q.out_on) begin
            st_d.rise = ~st_q.rise;
            st_d.auto = 1'b0;
            st_d.fall = 1'b0;
         end else if (st_q.fall) begin
            st_d.rise = 1'b1;
            st_d.fall = 1'b0;
            st_d.seq = SEQ_RUN;
         end
      end
      if (kp[K_FALL]) begin
         if (!st_q.out_on) begin
            st_d.fall = ~st_q.fall;
            st_d.auto = 1'b0;
            st_d.rise = 1'b0;
         end else if (st_q.rise) begin
            st_d.fall = 1'b1;
            st_d.rise = 1'b0;
            st_d.seq = SEQ_RUN;
         end
      end
      if (kp[K_RPT]) begin
         st_d.rpt = ~st_q.rpt;
      end
      if (kp[K_HOLD] && st_q.out_on && seq_mode && st_q.seq == SEQ_RUN) begin
         st_d.hold = ~st_q.hold;
      end
      if (kp[K_IVL]) begin
         st_d.disp = (st_q.disp == DISP_STEP_IVL) ? DISP_SWEEP_IVL :
            (st_q.disp == DISP_SWEEP_IVL) ? DISP_SETPOINT : DISP_STEP_IVL;
      end
      st_d.ivl_led = (st_d.disp != DISP_SETPOINT);
      // value edits
      if ((kp[K_DUP] || kp[K_DDN]) && edit_ok) begin
         case (st_q.disp)
            DISP_STEP_IVL: st_d.step_ivl = edited;
            DISP_SWEEP_IVL: st_d.sweep_ivl = edited;
            default: st_d.setpt = edited;
         endcase
      end
      if (wr && edit_ok) begin
         case (AVS_ADDRESS)
            OFS_SETPT: st_d.setpt = wd[15:0];
            OFS_STEP_IVL: st_d.step_ivl = wd[15:0];
            OFS_SWEEP_IVL: st_d.sweep_ivl = wd[15:0];
            OFS_DIVIDER: begin
               if (wd[DIV_M_LSB +: DIV_W] >= 5'(DIV_MIN) && wd[DIV_M_LSB +: DIV_W] <= 5'(DIV_MAX)
                  && wd[DIV_N_LSB +: DIV_W] <= wd[DIV_M_LSB +: DIV_W]) begin
                  st_d.m = wd[DIV_M_LSB +: DIV_W];
                  st_d.n = wd[DIV_N_LSB +: DIV_W];
               end
            end
            default: ;
         endcase
      end
      if (edit_ok) begin
         if (kp[K_MUP] && st_q.m < 5'(DIV_MAX)) begin
            st_d.m = st_q.m + 5'h01;
         end
         if (kp[K_MDN] && st_q.m > 5'(DIV_MIN)) begin
            st_d.m = st_q.m - 5'h01;
            st_d.n = (st_q.n > st_d.m) ? st_d.m : st_q.n;
         end
         if (kp[K_NUP] && st_q.n < st_q.m) begin
            st_d.n = st_q.n + 5'h01;
         end
         if (kp[K_NDN] && st_q.n > 5'h00) begin
            st_d.n = st_q.n - 5'h01;
         end
      end
      if (kp[K_CLR] && !(st_q.out_on && seq_mode)) begin
         st_d.setpt = '0;
      end
      // output key
      if (kp[K_OUT]) begin
         st_d.out_on = ~st_q.out_on;
         st_d.hold = 1'b0;
         st_d.timer = '0;
         st_d.cur = st_q.n;
         st_d.wrapped = 1'b0;
         st_d.pct = st_d.fall ? 7'(SWEEP_STEPS) : 7'h00;
         st_d.seq = (!st_q.out_on && (st_d.auto | st_d.rise | st_d.fall)) ? SEQ_RUN : SEQ_IDLE;
      end
      if (kp[K_ARST]) begin
         st_d.alarm = 1'b0;
      end
      // a fault in the clear cycle still latches
      if (SUPPLY_PRESSURE_FAULT && st_q.out_on) begin
         st_d.alarm = 1'b1;
         st_d.out_on = 1'b0;
      end
      if (st_q.out_on && !st_d.out_on) begin
         st_d.auto = 1'b0;
         st_d.rise = 1'b0;
         st_d.fall = 1'b0;
         st_d.hold = 1'b0;
         st_d.seq = SEQ_IDLE;
      end
      // servo follows the setpoint only while output is on
      st_d.servo = st_q.out_on ? scaled : '0;
      st_d.servo_en = st_q.out_on;
      st_d.v_close = st_q.servo_en && DELIVERED_PRESSURE > st_q.servo;
      st_d.v_open = st_q.servo_en && DELIVERED_PRESSURE < st_q.servo;
      if (!RST_N) begin
         st_d = '0;
         st_d.wt = 1'b1;
         st_d.disp = DISP_SETPOINT;
         st_d.seq = SEQ_IDLE;
         st_d.setpt = SETPT_RST;
         st_d.step_ivl = IVL_RST;
         st_d.sweep_ivl = IVL_RST;
         st_d.m = DIV_M_RST;
         st_d.n = DIV_N_RST;
      end
   end

   always_ff @(posedge CLK) begin
      st_q <= st_d;
   end

   assign AVS_READDATA = st_q.rdata;
   assign AVS_WAITREQUEST = st_q.wt;
   assign SERVO_SETPOINT = st_q.servo;
   assign SERVO_ENABLE = st_q.servo_en;
   assign VALVE_OPEN = st_q.v_open;
   assign VALVE_CLOSE = st_q.v_close;
   assign LED_OUTPUT = st_q.out_on;
   assign LED_AUTO = st_q.auto;
   assign LED_RISE = st_q.rise;
   assign LED_FALL = st_q.fall;
   assign LED_INTERVAL = st_q.ivl_led;
   assign LED_REPEAT = st_q.rpt;
   assign LED_HOLD = st_q.hold;
   assign LED_ALARM = st_q.alarm;

   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence on_press;
      kp[K_OUT] && !st_q.out_on;
   endsequence
   sequence lamp_then_servo;
      LED_OUTPUT ##1 SERVO_ENABLE;
   endsequence
   output_on_a: assert property (on_press |=> lamp_then_servo)
      else $error("output key did not turn output on");
   mode_lock_a: assert property ($past(st_q.out_on) && st_q.out_on |-> $stable(st_q.auto))
      else $error("auto-step mode changed while output on");
   off_manual_a: assert property ($fell(st_q.out_on) |-> !(LED_AUTO | LED_RISE | LED_FALL))
      else $error("mode not manual after output off");
   alarm_off_a: assert property ($rose(LED_ALARM) |-> !LED_OUTPUT)
      else $error("alarm raised but output still on");
   disp_cycle_a: assert property (kp[K_IVL] && st_q.disp == DISP_STEP_IVL
      |=> st_q.disp == DISP_SWEEP_IVL)
      else $error("display did not move to sweep interval");
   ivl_lamp_a: assert property (LED_INTERVAL == (st_q.disp != DISP_SETPOINT))
      else $error("interval lamp disagrees with display");
   hold_freeze_a: assert property (LED_HOLD && $past(LED_HOLD)
      |-> $stable(st_q.cur) && $stable(st_q.pct))
      else $error("level moved while held");
   edit_lock_a: assert property ($past(seq_mode) && !$past(kp[K_CLR] && !st_q.out_on)
      |-> $stable(st_q.setpt))
      else $error("setpoint edited in sequence mode");
   valve_dir_a: assert property (SERVO_ENABLE && DELIVERED_PRESSURE > SERVO_SETPOINT
      |=> VALVE_CLOSE && !VALVE_OPEN)
      else $error("valve not closing on overpressure");
   div_range_a: assert property (st_q.m >= 5'(DIV_MIN) && st_q.m <= 5'(DIV_MAX)
      && st_q.n <= st_q.m)
      else $error("divider ratio out of range");
endmodule

/* dv/servo_plant.sv */
// plant model of the pneumatic far side: delivered pressure creeps with the valve commands
// assumes registered valve levels; slow moves once in four cycles, otherwise every cycle
`timescale 1ns/100ps
module servo_plant
   import seq_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // valve commands and pace
   input wire logic valve_open,
   input wire logic valve_close,
   input wire logic slow,
   // measured pressure
   output logic [LVL_W-1:0] pressure_q
);
   logic [1:0] pace_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pace_q <= 2'h0;
         pressure_q <= '0;
      end else begin
         pace_q <= pace_q + 2'h1;
         // both commands at once would be a fault; the model then just holds
         if (!slow || pace_q == 2'h0) begin
            if (valve_open && !valve_close) pressure_q <= pressure_q + LVL_W'(1);
            else if (valve_close && !valve_open) pressure_q <= pressure_q - LVL_W'(1);
         end
      end
   end
endmodule

/* dv/pressure_output_sequencer_bench.sv */
// self-checking bench: register bus master, key presses, level model with a queue
// assumes the plant model beside it and a tick shortened to 4 cycles
`timescale 1ns/100ps
module pressure_output_sequencer_bench;
   import seq_pkg::*;
   logic CLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, SUPPLY_PRESSURE_FAULT, slow;
   logic [5:0] AVS_ADDRESS;
   logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd, rnd, sp_b;
   logic [3:0] AVS_BYTEENABLE;
   logic [LVL_W-1:0] DELIVERED_PRESSURE, SERVO_SETPOINT;
   logic SERVO_ENABLE, VALVE_OPEN, VALVE_CLOSE, LED_OUTPUT, LED_AUTO, LED_RISE, LED_FALL;
   logic LED_INTERVAL, LED_REPEAT, LED_HOLD, LED_ALARM;
   int miscompares, checks, k, lvl[$];
   logic [31:0] bad_div[3] = '{32'h0115, 32'h0100, 32'h0403};

   pressure_output_sequencer #(.TICK_CYCLES(4)) dut_u (.CLK, .RST_N, .AVS_ADDRESS, .AVS_READ,
      .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
      .SUPPLY_PRESSURE_FAULT, .DELIVERED_PRESSURE, .SERVO_SETPOINT, .SERVO_ENABLE, .VALVE_OPEN,
      .VALVE_CLOSE, .LED_OUTPUT, .LED_AUTO, .LED_RISE, .LED_FALL, .LED_INTERVAL, .LED_REPEAT,
      .LED_HOLD, .LED_ALARM);
   servo_plant plant_u (.clk(CLK), .rst_n(RST_N), .valve_open(VALVE_OPEN),
      .valve_close(VALVE_CLOSE), .slow(slow), .pressure_q(DELIVERED_PRESSURE));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // holds the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      for (n = 0; n < 20; n++) begin
         @(posedge CLK);
         if (AVS_WAITREQUEST === 1'b0) break;
      end
      rd = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
      if (n == 20) begin
         miscompares++;
         results();
      end
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // key effects land on the answer edge itself
   task automatic key(input int b, input logic [1:0] sel = 2'h0);
      bus(1'b1, OFS_KEY, (32'h1 << b) | (32'(sel) << DIGIT_SEL_LSB));
      repeat (2) @(posedge CLK);
   endtask
   task automatic wait_sp(input logic [LVL_W-1:0] e, input int bound);
      for (int n = 0; n < bound && SERVO_SETPOINT !== e; n++) @(posedge CLK);
      chk(SERVO_SETPOINT, e);
   endtask

   initial begin
      CLK = 1'b0;
      forever #2.5 CLK = ~CLK;
   end
   initial begin
      {AVS_READ, AVS_WRITE, SUPPLY_PRESSURE_FAULT, slow, RST_N} = '0;
      AVS_ADDRESS = 6'h00;
      AVS_WRITEDATA = 32'h0;
      AVS_BYTEENABLE = 4'hF;
      rnd = 32'h55D8;
      repeat (3) @(posedge CLK);
      RST_N <= 1'b1;
      rdc(OFS_STATUS, 32'h2);
      rdc(OFS_STEP_IVL, 32'h1);
      rdc(OFS_DIVIDER, 32'h0101);
      bus(1'b1, 6'h20, 32'hFFFF);
      rdc(6'h20, 32'h0);
      for (k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         for (int i = 0; i < 4; i++) sp_b[4*i+:4] = 4'((rnd >> (8 * i)) % 10);
         bus(1'b1, OFS_SETPT, {16'h0, sp_b[15:0]});
         rdc(OFS_SETPT, {16'h0, sp_b[15:0]});
      end
      foreach (bad_div[i]) bus(1'b1, OFS_DIVIDER, bad_div[i]);
      rdc(OFS_DIVIDER, 32'h0101);
      bus(1'b1, OFS_DIVIDER, 32'h0204);
      rdc(OFS_DIVIDER, 32'h0204);
      for (k = 0; k < 3; k++) begin
         key(K_IVL);
         bus(1'b0, OFS_STATUS, 32'h0);
         chk(rd[1:0], k);
         chk({rd[6], LED_INTERVAL}, (k < 2) ? 2'h3 : 2'h0);
         if (k == 0) begin
            key(K_DUP, 2'h0);
            rdc(OFS_STEP_IVL, 32'h2);
            key(K_DDN, 2'h0);
         end
      end
      bus(1'b1, OFS_SETPT, 32'h0040);
      key(K_DUP, 2'h1);
      key(K_DDN, 2'h0);
      rdc(OFS_SETPT, 32'h0059);
      key(K_CLR);
      rdc(OFS_SETPT, 32'h0);
      bus(1'b1, OFS_SETPT, 32'h0040);
      key(K_OUT);
      chk(LED_OUTPUT, 1'b1);
      wait_sp(14'd20, 100);
      for (k = 0; k < 3000 && (DELIVERED_PRESSURE + 2 < SERVO_SETPOINT ||
           DELIVERED_PRESSURE > SERVO_SETPOINT + 2); k++) @(posedge CLK);
      chk(k < 3000, 1'b1);
      key(K_AUTO);
      chk(LED_AUTO, 1'b0);
      key(K_OUT);
      chk(LED_OUTPUT, 1'b0);
      wait_sp(14'd0, 10);
      key(K_AUTO);
      chk(LED_AUTO, 1'b1);
      bus(1'b1, OFS_SETPT, 32'h0099);
      rdc(OFS_SETPT, 32'h0040);
      slow <= 1'b1;
      // 2..4 then 0..2 of four divisions of 40
      for (k = 2; k <= 4; k++) lvl.push_back(40 * k / 4);
      for (k = 0; k <= 2; k++) lvl.push_back(40 * k / 4);
      key(K_OUT);
      foreach (lvl[i]) begin
         wait_sp(LVL_W'(lvl[i]), 1000);
         if (i == 1) begin
            key(K_HOLD);
            chk(LED_HOLD, 1'b1);
            key(K_CLR);
            rdc(OFS_SETPT, 32'h0040);
            repeat (900) @(posedge CLK);
            chk(SERVO_SETPOINT, 14'd30);
            key(K_HOLD);
            chk(LED_HOLD, 1'b0);
         end
      end
      repeat (900) @(posedge CLK);
      chk(SERVO_SETPOINT, 14'd20);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(rd[10], 1'b1);
      key(K_OUT);
      chk(LED_AUTO, 1'b0);
      bus(1'b1, OFS_SETPT, 32'h0100);
      bus(1'b1, OFS_SWEEP_IVL, 32'h0030);
      key(K_RPT);
      chk(LED_REPEAT, 1'b1);
      key(K_RISE);
      chk(LED_RISE, 1'b1);
      key(K_OUT);
      wait_sp(14'd100, 13000);
      wait_sp(14'd0, 400);
      key(K_FALL);
      chk({LED_FALL, LED_RISE}, 2'h2);
      wait_sp(14'd100, 2000);
      key(K_RISE);
      chk({LED_FALL, LED_RISE}, 2'h1);
      SUPPLY_PRESSURE_FAULT <= 1'b1;
      repeat (3) @(posedge CLK);
      chk({LED_ALARM, LED_OUTPUT, LED_RISE}, 3'h4);
      SUPPLY_PRESSURE_FAULT <= 1'b0;
      key(K_ARST);
      chk(LED_ALARM, 1'b0);
      key(K_RPT);
      chk(LED_REPEAT, 1'b0);
      results();
   end
endmodule
